/* File: lpsc_pkg.sv */
// Package for the low power state controller: levels, timing and carriers
package lpsc_pkg;

    // ************************************************************
    // Levels and package states
    // ************************************************************
    typedef enum logic [2:0] {
        LVL_RUN,
        LVL_OPPORTUNISTIC,
        LVL_PERVASIVE,
        LVL_FLOOR,
        LVL_EXIT
    } lpsc_level_t;

    // Processor package idle state as reported by the processor
    localparam logic [3:0] PKG_C0  = 4'h0;
    localparam logic [3:0] PKG_C6  = 4'h6;
    localparam logic [3:0] PKG_C10 = 4'ha;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLOCK_MHZ         = 50;
    localparam int RAMP_CFG_W        = 8;
    localparam logic [RAMP_CFG_W-1:0] RAMP_CFG_RESET = 8'h04;
    localparam int EXIT_SETTLE_NS    = 100;
    localparam int EXIT_SETTLE_CYC   = (EXIT_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int PRESCALE_CYC      = 16;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic linkL1;
        logic pllOff;
        logic rootPllOff;
        logic xtalOff;
    } lpsc_clk_ctl_t;

    typedef struct packed {
        logic idleFloorN;
        logic deepIdleGateN;
        logic hsioGateN;
        logic sramGateN;
    } lpsc_pins_t;

endpackage

/* File: low_power_state_controller.sv */
// Low power state controller: idle level escalation, clock gating and rail gate pins
//
// Functional notes
// - Running package allows opportunistic level actions
// - C6 or deeper adds root PLL shutdown
// - C10 adds crystal shutdown and floor indicator
// - Crystal off needs C10, floor, no requests
// - Each interface gates own PLL when idle
// - Each unit power gates itself when idle
// - Deep idle gate asserted entering C10
// - Two active-low FET gates for HSIO, SRAM
// - FET ramp time set by configuration
// - Floor indicator active-low, hardware driven
`timescale 1ns/100ps
module lpsc_low_power_state_controller #(
    parameter int NUM_IO    = 4,
    parameter int NUM_UNITS = 4
) (
    input  wire logic                             clock,
    input  wire logic                             resetn,
    input  wire logic [3:0]                       pkgState,
    input  wire logic                             lowPowerEnable,
    input  wire logic                             standbyEnable,
    input  wire logic [lpsc_pkg::RAMP_CFG_W-1:0]  phySupplyRampConfig,
    input  wire logic                             xtalClockRequest,
    input  wire logic [NUM_IO-1:0]                ioLinkIdle,
    input  wire logic [NUM_UNITS-1:0]             unitIdle,
    output lpsc_pkg::lpsc_level_t                 level,
    output lpsc_pkg::lpsc_clk_ctl_t               clkCtl,
    output logic [NUM_IO-1:0]                     ioPllOff,
    output logic [NUM_UNITS-1:0]                  unitPowerGate,
    output logic                                  idleFloorIndicatorN,
    output logic                                  processorDeepIdleGateN,
    output logic                                  hsioSupplyGateN,
    output logic                                  sramSupplyGateN
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    // Prescaler is four bits and settle counter eight bits wide
    if (NUM_IO < 1 || NUM_UNITS < 1 || lpsc_pkg::PRESCALE_CYC < 1
        || lpsc_pkg::PRESCALE_CYC > 16 || lpsc_pkg::EXIT_SETTLE_CYC > 255)
    begin
        $error("Counts or timing constants out of range");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        lpsc_pkg::lpsc_level_t         level;
        lpsc_pkg::lpsc_clk_ctl_t       clk;
        lpsc_pkg::lpsc_pins_t          pins;
        logic [lpsc_pkg::RAMP_CFG_W-1:0] rampCnt;
        logic [3:0]                    preCnt;
        logic [7:0]                    exitCnt;
        logic [NUM_IO-1:0]             ioOff;
        logic [NUM_UNITS-1:0]          unitGate;
    } lpsc_state_t;

    localparam logic [7:0] EXIT_CYC = 8'(lpsc_pkg::EXIT_SETTLE_CYC);
    localparam logic [3:0] PRE_LAST = 4'(lpsc_pkg::PRESCALE_CYC - 1);

    lpsc_state_t state_q;
    lpsc_state_t state_d;

    logic isC6Deep;
    logic isC10;
    logic rampTick;
    logic rampDone;

    assign isC6Deep = (pkgState >= lpsc_pkg::PKG_C6);
    assign isC10    = (pkgState == lpsc_pkg::PKG_C10);
    assign rampTick = (state_q.preCnt == PRE_LAST);
    assign rampDone = (state_q.rampCnt == '0);

    always_comb
    begin
        state_d = state_q;
        state_d.preCnt = rampTick ? 4'h0 : state_q.preCnt + 4'h1;
        if (rampTick && !rampDone)
            state_d.rampCnt = state_q.rampCnt - 1'b1;
        unique case (state_q.level)
            lpsc_pkg::LVL_RUN:
            begin
                if (lowPowerEnable)
                    state_d.level = lpsc_pkg::LVL_OPPORTUNISTIC;
            end
            lpsc_pkg::LVL_OPPORTUNISTIC:
            begin
                state_d.clk.linkL1 = 1'b1;
                state_d.clk.pllOff = 1'b1;
                if (!lowPowerEnable)
                    state_d.level = lpsc_pkg::LVL_EXIT;
                else if (isC6Deep)
                    state_d.level = lpsc_pkg::LVL_PERVASIVE;
            end
            lpsc_pkg::LVL_PERVASIVE:
            begin
                state_d.clk.rootPllOff = 1'b1;
                if (!lowPowerEnable || !isC6Deep)
                    state_d.level = lpsc_pkg::LVL_EXIT;
                else if (isC10)
                begin
                    state_d.level = lpsc_pkg::LVL_FLOOR;
                    state_d.rampCnt = phySupplyRampConfig;
                end
            end
            lpsc_pkg::LVL_FLOOR:
            begin
                if (!lowPowerEnable || !isC10)
                begin
                    // Pins released first, clocks stay off until settle ends
                    state_d.pins = '1;
                    state_d.exitCnt = EXIT_CYC;
                    state_d.level = lpsc_pkg::LVL_EXIT;
                end
                else
                begin
                    state_d.pins.idleFloorN = 1'b0;
                    state_d.pins.deepIdleGateN = 1'b0;
                    state_d.clk.xtalOff = !xtalClockRequest;
                    if (rampDone)
                    begin
                        state_d.pins.hsioGateN = 1'b0;
                        state_d.pins.sramGateN = !standbyEnable;
                    end
                end
            end
            lpsc_pkg::LVL_EXIT:
            begin
                state_d.pins = '1;
                if (state_q.exitCnt != 8'h00)
                    state_d.exitCnt = state_q.exitCnt - 8'h01;
                else
                begin
                    state_d.clk = '0;
                    state_d.level = lpsc_pkg::LVL_RUN;
                end
            end
            default:
                state_d.level = lpsc_pkg::LVL_RUN;
        endcase
        state_d.ioOff = ioLinkIdle;
        state_d.unitGate = unitIdle;
        if (!lowPowerEnable)
        begin
            state_d.ioOff = '0;
            state_d.unitGate = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state_q.level <= lpsc_pkg::LVL_RUN;
            state_q.clk <= '0;
            state_q.pins <= '1;
            state_q.rampCnt <= lpsc_pkg::RAMP_CFG_RESET;
            state_q.preCnt <= 4'h0;
            state_q.exitCnt <= 8'h00;
            state_q.ioOff <= '0;
            state_q.unitGate <= '0;
        end
        else
            state_q <= state_d;
    end

    assign level = state_q.level;
    assign clkCtl = state_q.clk;
    assign ioPllOff = state_q.ioOff;
    assign unitPowerGate = state_q.unitGate;
    assign idleFloorIndicatorN = state_q.pins.idleFloorN;
    assign processorDeepIdleGateN = state_q.pins.deepIdleGateN;
    assign hsioSupplyGateN = state_q.pins.hsioGateN;
    assign sramSupplyGateN = state_q.pins.sramGateN;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_reference_crystal_conditions: assert property (clkCtl.xtalOff && level == lpsc_pkg::LVL_FLOOR
        |-> $past(isC10) && !$past(xtalClockRequest))
        else $error("Crystal off illegally");
    chk_root_pll: assert property ($rose(clkCtl.rootPllOff)
        |-> $past(level) == lpsc_pkg::LVL_PERVASIVE)
        else $error("Root PLL off early");
    chk_link_l1: assert property ($rose(clkCtl.linkL1)
        |-> $past(level) == lpsc_pkg::LVL_OPPORTUNISTIC)
        else $error("Link L1 wrong level");
    // Each deeper level keeps every action of the shallower ones
    chk_level_nesting: assert property (clkCtl.xtalOff
        |-> clkCtl.rootPllOff && clkCtl.linkL1 && clkCtl.pllOff)
        else $error("Deeper action without shallower ones");
    chk_floor_pin: assert property (!idleFloorIndicatorN
        |-> level == lpsc_pkg::LVL_FLOOR)
        else $error("Floor pin outside floor");
    chk_gate_c10: assert property ($fell(processorDeepIdleGateN)
        |-> $past(isC10))
        else $error("Deep idle gate without C10");
    chk_deep_floor: assert property (!processorDeepIdleGateN
        |-> level == lpsc_pkg::LVL_FLOOR)
        else $error("Deep idle gate outside floor");
    chk_fet_ramp: assert property ($fell(hsioSupplyGateN)
        |-> !idleFloorIndicatorN && $past(rampDone))
        else $error("FET before ramp");
    chk_fets_floor: assert property (!hsioSupplyGateN || !sramSupplyGateN
        |-> level == lpsc_pkg::LVL_FLOOR && !idleFloorIndicatorN)
        else $error("FET gate outside floor");
    chk_sram_standby: assert property ($fell(sramSupplyGateN)
        |-> $past(standbyEnable) && !hsioSupplyGateN)
        else $error("SRAM gate without standby");
    chk_exit_order: assert property ($fell(clkCtl.xtalOff) && level != lpsc_pkg::LVL_FLOOR
        |-> idleFloorIndicatorN && hsioSupplyGateN && sramSupplyGateN)
        else $error("Clock restart before pin release");
    chk_io_follow: assert property (lowPowerEnable ##1 lowPowerEnable
        |-> ioPllOff == $past(ioLinkIdle))
        else $error("IO PLL not following idle");
    chk_unit_follow: assert property (lowPowerEnable ##1 lowPowerEnable
        |-> unitPowerGate == $past(unitIdle))
        else $error("Unit gate not following");

    cov_floor: cover property (level == lpsc_pkg::LVL_FLOOR ##1 !hsioSupplyGateN);
    cov_standby_off: cover property (level == lpsc_pkg::LVL_FLOOR && !hsioSupplyGateN
        && sramSupplyGateN);
    cov_reference_crystal: cover property (clkCtl.xtalOff);
    cov_exit: cover property (level == lpsc_pkg::LVL_EXIT ##[1:20] level == lpsc_pkg::LVL_RUN);

endmodule

/* File: lpsc_proc_model.sv */
// Processor package and board regulator model for the low power state controller
`timescale 1ns/100ps
module lpsc_proc_model (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic [3:0] targetState,
    input  wire logic       otherXtalReq,
    input  wire logic       deepIdleGateN,
    output logic [3:0]      pkgState,
    output logic            xtalClockRequest,
    output logic            railUp,
    output logic            railPowerGood
);
    logic [1:0] rampQ;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            pkgState         <= lpsc_pkg::PKG_C0;
            xtalClockRequest <= 1'b1;
            rampQ            <= 2'h3;
        end
        else
        begin
            pkgState         <= targetState;
            xtalClockRequest <= otherXtalReq;
            // Rails drop while gated, climb back in a few cycles
            rampQ <= !deepIdleGateN ? 2'h0 : (rampQ == 2'h3 ? rampQ : rampQ + 2'h1);
        end
    end

    assign railUp        = (rampQ == 2'h3);
    // Power-good stays up through gating and ramp
    assign railPowerGood = 1'b1;
endmodule

/* File: lpsc_low_power_state_controller_tb_top.sv */
// Self-checking testbench for the low power state controller
`timescale 1ns/100ps
module lpsc_low_power_state_controller_tb_top;
    logic clock = 1'b0, resetn = 1'b0, otherXtalReq = 1'b1;
    logic lowPowerEnable = 1'b0, standbyEnable = 1'b0;
    logic [3:0] targetState = 4'h0, ioLinkIdle = 4'h0, unitIdle = 4'h0;
    logic [7:0] rampCfg = 8'h04;
    logic [3:0] pkgState, ioPllOff, unitPowerGate;
    logic xtalReq, railUp, railPg, floorN, deepN, hsioN, sramN;
    lpsc_pkg::lpsc_level_t   level;
    lpsc_pkg::lpsc_clk_ctl_t clkCtl;
    int num_errors = 0, cmp_count = 0, cycles = 0;

    lpsc_low_power_state_controller lpsc_low_power_state_controller_i (
        .clock(clock), .resetn(resetn), .pkgState(pkgState),
        .lowPowerEnable(lowPowerEnable), .standbyEnable(standbyEnable),
        .phySupplyRampConfig(rampCfg), .xtalClockRequest(xtalReq),
        .ioLinkIdle(ioLinkIdle), .unitIdle(unitIdle), .level(level), .clkCtl(clkCtl),
        .ioPllOff(ioPllOff), .unitPowerGate(unitPowerGate), .idleFloorIndicatorN(floorN),
        .processorDeepIdleGateN(deepN), .hsioSupplyGateN(hsioN), .sramSupplyGateN(sramN));

    lpsc_proc_model lpsc_proc_model_i (
        .clock(clock), .resetn(resetn), .targetState(targetState),
        .otherXtalReq(otherXtalReq), .deepIdleGateN(deepN), .pkgState(pkgState),
        .xtalClockRequest(xtalReq), .railUp(railUp), .railPowerGood(railPg));

    initial forever #10 clock = ~clock;

    task summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ************************************************************
    // Helpers
    // ************************************************************
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            summarize();
        end
    end

    task checkVal(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h", $time, msg, got);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task waitLvl(input lpsc_pkg::lpsc_level_t l);
        for (int k = 0; k < 20 && level !== l; k++)
            step(1);
        checkVal(8'(level), 8'(l), "level");
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task testEscalate();
        checkVal({floorN, deepN, hsioN, sramN, clkCtl}, 8'hf0, "reset outputs");
        standbyEnable = 1'b1;
        lowPowerEnable = 1'b1;
        waitLvl(lpsc_pkg::LVL_OPPORTUNISTIC);
        step(1);
        checkVal(8'(clkCtl), 8'h0c, "opportunistic actions");
        targetState = lpsc_pkg::PKG_C6;
        waitLvl(lpsc_pkg::LVL_PERVASIVE);
        step(1);
        checkVal(8'(clkCtl), 8'h0e, "root pll off");
        targetState = lpsc_pkg::PKG_C10;
        waitLvl(lpsc_pkg::LVL_FLOOR);
        step(2);
        checkVal({6'h0, floorN, deepN}, 8'h00, "floor pins low");
        checkVal(8'(clkCtl), 8'h0e, "crystal kept by request");
        otherXtalReq = 1'b0;
        step(3);
        checkVal(8'(clkCtl), 8'h0f, "crystal off");
        $display("escalate test done");
    endtask

    task testRamp();
        step(35);
        checkVal({6'h0, hsioN, sramN}, 8'h03, "fet gates before ramp");
        for (int k = 0; k < 60 && hsioN !== 1'b0; k++)
            step(1);
        checkVal({6'h0, hsioN, sramN}, 8'h00, "fet gates after ramp");
        checkVal({7'h0, railPg}, 8'h01, "rail power good");
        $display("ramp test done");
    endtask

    task testExit();
        targetState = lpsc_pkg::PKG_C0;
        otherXtalReq = 1'b1;
        waitLvl(lpsc_pkg::LVL_EXIT);
        checkVal({floorN, deepN, hsioN, sramN, clkCtl}, 8'hff, "pins before clocks");
        waitLvl(lpsc_pkg::LVL_RUN);
        checkVal(8'(clkCtl), 8'h00, "clocks restarted");
        checkVal({7'h0, railUp}, 8'h01, "rails ramped");
        $display("exit test done");
    endtask

    task testUnits();
        ioLinkIdle = 4'h5;
        unitIdle = 4'ha;
        step(3);
        checkVal({ioPllOff, unitPowerGate}, 8'h5a, "per unit gating");
        lowPowerEnable = 1'b0;
        step(3);
        checkVal({ioPllOff, unitPowerGate}, 8'h00, "gating released");
        $display("unit test done");
    endtask

    task testStandby();
        standbyEnable = 1'b0;
        rampCfg = 8'h00;
        targetState = lpsc_pkg::PKG_C6;
        lowPowerEnable = 1'b1;
        waitLvl(lpsc_pkg::LVL_OPPORTUNISTIC);
        waitLvl(lpsc_pkg::LVL_PERVASIVE);
        targetState = lpsc_pkg::PKG_C10;
        waitLvl(lpsc_pkg::LVL_FLOOR);
        step(1);
        checkVal({4'h0, floorN, deepN, hsioN, sramN}, 8'h01, "sram kept off standby");
        lowPowerEnable = 1'b0;
        waitLvl(lpsc_pkg::LVL_EXIT);
        checkVal({floorN, deepN, hsioN, sramN, clkCtl}, 8'hfe, "disable leaves floor");
        waitLvl(lpsc_pkg::LVL_RUN);
        targetState = lpsc_pkg::PKG_C6;
        lowPowerEnable = 1'b1;
        waitLvl(lpsc_pkg::LVL_OPPORTUNISTIC);
        waitLvl(lpsc_pkg::LVL_PERVASIVE);
        targetState = lpsc_pkg::PKG_C0;
        waitLvl(lpsc_pkg::LVL_EXIT);
        checkVal({floorN, deepN, hsioN, sramN, clkCtl}, 8'hfe, "shallower leaves pervasive");
        waitLvl(lpsc_pkg::LVL_RUN);
        lowPowerEnable = 1'b0;
        checkVal(8'(clkCtl), 8'h00, "clocks back on");
        $display("standby test done");
    endtask

    initial
    begin
        step(16);
        resetn = 1'b1;
        step(1);
        testEscalate();
        testRamp();
        testExit();
        testUnits();
        testStandby();
        summarize();
    end
endmodule
